// ===== design/ept_pkg.sv
// Package of constants and types for the parallel port transfer sequencer.
package ept_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMEOUT_US = 10;
  localparam int TO_CYC = (TIMEOUT_US * CLK_HZ) / 1_000_000;
  localparam int TO_W = 9;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic RST_HIGH = 1'b1;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DIR = 4'h1,
    ST_STRB = 4'h3,
    ST_REL1 = 4'h2,
    ST_REL2 = 4'h6,
    ST_W9LO = 4'h5,
    ST_S9DIR = 4'h4,
    ST_S9STRB = 4'hC,
    ST_S9HOLD = 4'hD,
    ST_S9TAIL = 4'hF,
    ST_ABORT = 4'hE
  } ept_state_t;
endpackage : ept_pkg

// ===== design/ept_sequencer.sv
// Enhanced parallel port transfer sequencer, host strobes to peripheral.
`timescale 1ns/1ps
`default_nettype none
module ept_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host bus
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic sel_addr,
  input wire logic sel_data,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  output logic host_ready,
  output logic zero_wait_n,
  // Mode selection
  input wire logic rev19_mode,
  input wire logic zws_enable,
  // Timeout status
  output logic timeout_flag,
  input wire logic timeout_clr,
  // Peripheral side
  input wire logic periph_wait,
  input wire logic [7:0] periph_data_in,
  output logic [7:0] periph_data_out,
  output logic periph_data_oe_n,
  output logic periph_write_n,
  output logic addr_strobe_n,
  output logic data_strobe_n
);
  import ept_pkg::*;

  typedef struct packed {
    ept_state_t st;
    logic is_wr;
    logic is_addr;
    logic seen_lo;
    logic pend;
    logic [7:0] pd_out;
    logic [7:0] hd_out;
    logic hd_oe_n;
    logic pd_oe_n;
    logic write_n;
    logic astb_n;
    logic dstb_n;
    logic rdy;
    logic zws_n;
    logic [TO_W-1:0] to_cnt;
    logic to_flag;
    logic rd_p;
    logic wr_p;
  } ept_regs_t;

  localparam ept_regs_t REGS_RST = '{
    st: ST_IDLE, is_wr: 1'b0, is_addr: 1'b0, seen_lo: 1'b0, pend: 1'b0,
    pd_out: RST_DATA, hd_out: RST_DATA, hd_oe_n: RST_HIGH,
    pd_oe_n: RST_HIGH, write_n: RST_HIGH, astb_n: RST_HIGH,
    dstb_n: RST_HIGH, rdy: RST_HIGH, zws_n: RST_HIGH,
    to_cnt: '0, to_flag: 1'b0, rd_p: RST_HIGH, wr_p: RST_HIGH
  };

  ept_regs_t q;
  ept_regs_t d;
  logic [2:0] sync_lv;
  logic rd_s;
  logic wr_s;
  logic wait_s;
  logic rd_fall;
  logic wr_fall;
  logic host_end;
  logic abort;
  logic active_rd;

  // Wait and host strobes cross in through two flip-flops each.
  ept_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({host_rd_n, host_wr_n, periph_wait}),
    .sync_out(sync_lv)
  );

  assign rd_s = sync_lv[2];
  assign wr_s = sync_lv[1];
  assign wait_s = sync_lv[0];

  // Drives whichever strobe belongs to the register being accessed.
  function automatic ept_regs_t set_strobe(ept_regs_t r, logic lvl);
    ept_regs_t o;
    o = r;
    if (r.is_addr) begin
      o.astb_n = lvl;
    end else begin
      o.dstb_n = lvl;
    end
    return o;
  endfunction : set_strobe

  always_comb begin
    d = q;
    rd_fall = q.rd_p & ~rd_s;
    wr_fall = q.wr_p & ~wr_s;
    host_end = q.is_wr ? wr_s : rd_s;
    abort = ~q.rdy && (q.to_cnt == TO_W'(TO_CYC - 1)) && (q.st != ST_IDLE);
    active_rd = ~q.is_wr && (q.st != ST_IDLE) && (q.st != ST_REL1)
                && (q.st != ST_REL2) && (q.st != ST_ABORT);
    d.rd_p = rd_s;
    d.wr_p = wr_s;
    if (timeout_clr) begin
      d.to_flag = 1'b0;
    end
    if (!q.rdy) begin
      d.to_cnt = q.to_cnt + TO_W'(1);
    end else begin
      d.to_cnt = '0;
    end
    // The read path follows the lines until the host strobe rises, then holds.
    if (active_rd) begin
      d.hd_out = periph_data_in;
    end
    unique case (q.st)
      ST_IDLE: begin
        if ((rd_fall || wr_fall || q.pend) && (sel_addr || sel_data)) begin
          d.is_wr = wr_fall | q.pend;
          d.is_addr = sel_addr;
          d.seen_lo = 1'b0;
          d.pend = 1'b0;
          if (wr_fall || q.pend) begin
            d.pd_out = host_data_in;
          end else begin
            d.hd_oe_n = 1'b0;
          end
          if (rev19_mode) begin
            d.rdy = 1'b0;
            d.st = ST_W9LO;
            if (!wait_s) begin
              // Wait already low, so the next step happens at once.
              if (wr_fall || q.pend) begin
                d.write_n = 1'b0;
                d.pd_oe_n = 1'b0;
                d.st = ST_S9DIR;
              end else begin
                d = set_strobe(d, 1'b0);
                d.st = ST_S9STRB;
              end
            end
          end else begin
            if (wr_fall || q.pend) begin
              d.write_n = 1'b0;
              d.pd_oe_n = 1'b0;
            end
            d.st = ST_DIR;
          end
        end
      end
      ST_DIR: begin
        d = set_strobe(d, 1'b0);
        d.st = ST_STRB;
      end
      ST_STRB: begin
        if (!wait_s) begin
          d.rdy = 1'b0;
          d.seen_lo = 1'b1;
          d.zws_n = 1'b1;
        end else begin
          d.rdy = 1'b1;
          if (zws_enable && !q.seen_lo) begin
            d.zws_n = 1'b0;
          end
        end
        if (host_end && q.rdy) begin
          d = set_strobe(d, 1'b1);
          d.rdy = 1'b1;
          d.st = ST_REL1;
        end
      end
      ST_REL1: begin
        d.zws_n = 1'b1;
        d.hd_oe_n = 1'b1;
        d.st = ST_REL2;
      end
      ST_REL2: begin
        d.write_n = 1'b1;
        d.pd_oe_n = 1'b1;
        d.st = ST_IDLE;
      end
      ST_W9LO: begin
        if (!wait_s) begin
          if (q.is_wr) begin
            d.write_n = 1'b0;
            d.pd_oe_n = 1'b0;
            d.st = ST_S9DIR;
          end else begin
            d = set_strobe(d, 1'b0);
            d.st = ST_S9STRB;
          end
        end
      end
      ST_S9DIR: begin
        d = set_strobe(d, 1'b0);
        d.st = ST_S9STRB;
      end
      ST_S9STRB: begin
        if (wait_s) begin
          d.rdy = 1'b1;
          d.st = ST_S9HOLD;
        end
      end
      ST_S9HOLD: begin
        if (host_end) begin
          d = set_strobe(d, 1'b1);
          d.hd_oe_n = 1'b1;
          d.st = q.is_wr ? ST_S9TAIL : ST_IDLE;
        end
      end
      ST_S9TAIL: begin
        if (!wait_s) begin
          // A follow-on host write keeps the direction low across cycles.
          if (!wr_s && (sel_addr || sel_data)) begin
            d.pend = 1'b1;
          end else begin
            d.write_n = 1'b1;
            d.pd_oe_n = 1'b1;
          end
          d.st = ST_IDLE;
        end
      end
      ST_ABORT: begin
        if (host_end) begin
          d.st = ST_REL1;
        end
      end
      default: begin
        d = REGS_RST;
      end
    endcase
    // A stuck peripheral must not hold the host bus forever.
    if (abort) begin
      d.rdy = 1'b1;
      d.astb_n = 1'b1;
      d.dstb_n = 1'b1;
      d.zws_n = 1'b1;
      d.pend = 1'b0;
      d.to_flag = 1'b1;
      d.to_cnt = '0;
      d.st = ST_ABORT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign host_data_out = q.hd_out;
  assign host_data_oe_n = q.hd_oe_n;
  assign host_ready = q.rdy;
  assign zero_wait_n = q.zws_n;
  assign timeout_flag = q.to_flag;
  assign periph_data_out = q.pd_out;
  assign periph_data_oe_n = q.pd_oe_n;
  assign periph_write_n = q.write_n;
  assign addr_strobe_n = q.astb_n;
  assign data_strobe_n = q.dstb_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence strobes_high_s;
    addr_strobe_n && data_strobe_n;
  endsequence

  sequence release_tail_s;
    ##1 zero_wait_n ##1 periph_write_n && periph_data_oe_n;
  endsequence

  wr17_start_a: assert property (
    (q.st == ST_IDLE && d.st == ST_DIR && d.is_wr)
    |=> !periph_write_n && !periph_data_oe_n
        && periph_data_out == $past(host_data_in)
  ) else $error("1.7 write did not drive data with direction low");

  strobe_after_a: assert property (
    (q.st == ST_DIR && !abort)
    |=> (q.is_addr ? !addr_strobe_n : !data_strobe_n)
  ) else $error("strobe not asserted after direction step");

  ready_wait_a: assert property (
    (q.st == ST_STRB && !abort && !(host_end && q.rdy))
    |=> (host_ready == $past(wait_s))
  ) else $error("ready does not follow wait in 1.7 cycle");
  release_order_a: assert property (
    (q.st == ST_REL1) |-> strobes_high_s ##0 release_tail_s
  ) else $error("release order of strobe, zero wait, direction broken");

  data_stable_a: assert property (
    $changed(periph_data_out)
    |-> $past(addr_strobe_n && data_strobe_n)
        && ($past(periph_write_n) || $past(q.pend))
  ) else $error("peripheral data changed while strobe or direction low");

  read_gate_a: assert property (
    (q.st == ST_STRB && !q.is_wr) |-> !host_data_oe_n && periph_write_n
  ) else $error("1.7 read not gating data or direction not high");

  bus_release_a: assert property (
    $rose(host_data_oe_n) |-> strobes_high_s
  ) else $error("host bus released before strobe went high");

  zws_assert_a: assert property (
    (q.st == ST_STRB && wait_s && zws_enable && !q.seen_lo && !abort)
    |=> !zero_wait_n && host_ready
  ) else $error("zero wait not signalled with wait high");

  zws_blocked_a: assert property (
    (q.st == ST_STRB && !wait_s && !abort && !(host_end && q.rdy))
    |=> zero_wait_n && !host_ready
  ) else $error("early wait low did not fall back to normal write");
  r19_dir_a: assert property (
    (q.st == ST_W9LO && !wait_s && q.is_wr && !abort)
    |=> !periph_write_n && !host_ready
  ) else $error("1.9 write direction not low after wait low");

  r19_ready_a: assert property (
    (q.st == ST_S9STRB && wait_s && !abort) |=> host_ready [*2]
  ) else $error("1.9 ready not released after wait high");

  timeout_abort_a: assert property (
    (!host_ready && q.to_cnt == TO_W'(TO_CYC - 1) && q.st != ST_IDLE)
    |=> host_ready && timeout_flag && addr_strobe_n && data_strobe_n
  ) else $error("timeout did not abort the stuck cycle");
endmodule : ept_sequencer
`default_nettype wire

// ===== design/ept_sync.sv
// Two-stage synchroniser bank for the handshake inputs.
`timescale 1ns/1ps
`default_nettype none
module ept_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // Resets to all ones because both host strobes and the 1.7 wait line are inactive high; 1.9 wait idles low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : ept_sync
`default_nettype wire

// ===== test/ept_periph.sv
// Peripheral model that answers the strobes with the wait handshake.
`timescale 1ns/1ps
`default_nettype none
module ept_periph (
  // Clock
  input wire logic clk,
  // Behaviour controls
  input wire logic rev19,
  input wire logic stall,
  input wire logic [1:0] lat,
  input wire logic [7:0] rd_byte,
  // Port side
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic periph_write_n,
  output logic periph_wait,
  output logic [7:0] periph_data_in
);
  logic strb;
  logic strb_q;
  int cnt;
  int age;
  assign strb = !(addr_strobe_n && data_strobe_n);
  // Age of the strobe level, zero on the edge that first sees it, so the
  // handshake never answers from a count left over by the previous level.
  assign age = (strb != strb_q) ? 0 : cnt + 1;
  initial begin
    periph_wait = 1'b1;
    periph_data_in = 8'h00;
    strb_q = 1'b0;
    cnt = 0;
  end
  always @(posedge clk) begin
    strb_q <= strb;
    cnt <= age;
    // A revision 1.9 peripheral idles low, ready to take a strobe.
    if (stall) periph_wait <= 1'b0;
    else if (rev19) periph_wait <= strb && age >= lat;
    else periph_wait <= !(strb && age < lat);
    // Released lines keep flipping so a stale byte never looks valid.
    if (strb && periph_write_n) periph_data_in <= rd_byte;
    else periph_data_in <= ~periph_data_in;
  end
endmodule : ept_periph
`default_nettype wire

// ===== test/ept_sequencer_bench.sv
// Self-checking bench for the transfer sequencer.
`timescale 1ns/1ps
`default_nettype none
module ept_sequencer_bench;
  logic clk, rst_n, host_rd_n, host_wr_n, sel_addr, sel_data;
  logic [7:0] host_data_in, host_data_out, periph_data_in, periph_data_out;
  logic host_data_oe_n, host_ready, zero_wait_n, rev19_mode, zws_enable;
  logic timeout_flag, timeout_clr, periph_wait, periph_data_oe_n;
  logic periph_write_n, addr_strobe_n, data_strobe_n, stall;
  logic [1:0] lat;
  logic [7:0] rd_byte, exp_byte;
  logic saw_rdy, saw_zws, saw_a, saw_d, bad_pd;
  int fails, n_tests, i;

  ept_sequencer dut (.clk(clk), .rst_n(rst_n), .host_rd_n(host_rd_n),
    .host_wr_n(host_wr_n), .sel_addr(sel_addr), .sel_data(sel_data),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe_n(host_data_oe_n), .host_ready(host_ready),
    .zero_wait_n(zero_wait_n), .rev19_mode(rev19_mode),
    .zws_enable(zws_enable), .timeout_flag(timeout_flag),
    .timeout_clr(timeout_clr), .periph_wait(periph_wait),
    .periph_data_in(periph_data_in), .periph_data_out(periph_data_out),
    .periph_data_oe_n(periph_data_oe_n), .periph_write_n(periph_write_n),
    .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n));
  ept_periph peer (.clk(clk), .rev19(rev19_mode), .stall(stall), .lat(lat),
    .rd_byte(rd_byte), .addr_strobe_n(addr_strobe_n),
    .data_strobe_n(data_strobe_n), .periph_write_n(periph_write_n),
    .periph_wait(periph_wait), .periph_data_in(periph_data_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Sticky observations over one transfer, cleared by the transfer task.
  always @(posedge clk) begin
    if (!host_ready) saw_rdy <= 1'b1;
    if (!zero_wait_n) saw_zws <= 1'b1;
    if (!addr_strobe_n) saw_a <= 1'b1;
    if (!data_strobe_n) saw_d <= 1'b1;
    // While a strobe is low the lines are driven exactly when writing.
    if (!(addr_strobe_n && data_strobe_n) &&
        (periph_data_oe_n !== periph_write_n ||
        (!periph_write_n && periph_data_out !== exp_byte))) bad_pd <= 1'b1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Bounded wait at falling edges; running out ends the run.
  task automatic wait_for(input int which, input int lim);
    int k;
    k = 0;
    while (k < lim && !((which == 0 && host_ready === 1'b1) ||
        (which == 1 && timeout_flag === 1'b1) || (which == 2 &&
        {periph_write_n, addr_strobe_n, data_strobe_n, host_data_oe_n}
        === 4'hF))) begin
      @(negedge clk);
      k++;
    end
    if (k == lim) begin
      fails++;
      final_report();
    end
  endtask : wait_for

  function automatic logic exp_rdy(input logic r19, input logic [1:0] l);
    return r19 || l != 2'h0;
  endfunction : exp_rdy

  task automatic xfer(input logic wr, input logic a, input logic r19,
      input logic z, input logic [1:0] l, input logic [7:0] b);
    @(negedge clk);
    rev19_mode = r19;
    zws_enable = z;
    lat = l;
    rd_byte = b;
    exp_byte = b;
    sel_addr = a;
    sel_data = !a;
    host_data_in = b;
    {saw_rdy, saw_zws, saw_a, saw_d, bad_pd} = 5'h00;
    if (wr) host_wr_n = 1'b0;
    else host_rd_n = 1'b0;
    repeat (10) @(negedge clk);
    wait_for(0, 300);
    if (!wr && !r19) check(host_data_out, b);
    check(host_data_oe_n, wr);
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    wait_for(2, 20);
    check(saw_rdy, exp_rdy(r19, l));
    check(saw_a, a);
    check(saw_d, !a);
    check(bad_pd, 1'b0);
    if (!wr && r19) check(host_data_out, b);
    if (!r19 && (l == 2'h0 || !z)) check(saw_zws, z && l == 2'h0);
    check(host_ready, 1'b1);
    $display("transfer wr=%0d rev19=%0d zws=%0d lat=%0d done", wr, r19, z, l);
  endtask : xfer

  initial begin
    // The host leaves the port strobes alone; only the sequencer drives them.
    {host_rd_n, host_wr_n, sel_addr, sel_data} = 4'hC;
    {rev19_mode, zws_enable, timeout_clr, stall} = 4'h0;
    host_data_in = 8'h00;
    lat = 2'h0;
    rd_byte = 8'h00;
    exp_byte = 8'h00;
    fails = 0;
    n_tests = 0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check({host_ready, zero_wait_n, timeout_flag}, 8'h06);
    void'($urandom(32'h9887));
    for (i = 0; i < 8; i++) xfer(i[0], i[1], i[2], 1'b0, 2'h1, 8'hA5);
    xfer(1'b1, 1'b1, 1'b0, 1'b1, 2'h0, 8'h3C);
    xfer(1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 8'hC3);
    for (i = 0; i < 24; i++) begin
      xfer(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
        2'($urandom), 8'($urandom));
    end
    // Back-to-back 1.9 writes: the second starts before the first tail ends,
    // so the direction must stay low across both cycles.
    @(negedge clk);
    rev19_mode = 1'b1;
    {sel_addr, sel_data} = 2'b01;
    lat = 2'h1;
    host_data_in = 8'h5A;
    exp_byte = 8'h5A;
    bad_pd = 1'b0;
    host_wr_n = 1'b0;
    repeat (10) @(negedge clk);
    wait_for(0, 300);
    host_wr_n = 1'b1;
    @(negedge clk);
    host_data_in = 8'h96;
    host_wr_n = 1'b0;
    for (i = 0; i < 10; i++) begin
      @(negedge clk);
      if (i == 2) exp_byte = 8'h96;
      check(periph_write_n, 1'b0);
    end
    wait_for(0, 300);
    host_wr_n = 1'b1;
    wait_for(2, 20);
    check(bad_pd, 1'b0);
    check(periph_data_out, 8'h96);
    $display("back-to-back write test done");
    @(negedge clk);
    rev19_mode = 1'b0;
    {sel_addr, sel_data} = 2'b01;
    stall = 1'b1;
    host_wr_n = 1'b0;
    wait_for(1, 400);
    check({host_ready, data_strobe_n, zero_wait_n}, 8'h07);
    host_wr_n = 1'b1;
    stall = 1'b0;
    repeat (8) @(negedge clk);
    timeout_clr = 1'b1;
    @(negedge clk);
    timeout_clr = 1'b0;
    @(negedge clk);
    check(timeout_flag, 1'b0);
    $display("timeout test done");
    final_report();
  end
endmodule : ept_sequencer_bench
`default_nettype wire
